// ===== hdl/umsb_pkg.sv
package umsb_pkg;
   // Register byte addresses (word per register)
   localparam logic [4:0] ADDR_RBR_THR_DLL = 5'h00;
   localparam logic [4:0] ADDR_IER_DLM = 5'h04;
   localparam logic [4:0] ADDR_LCR = 5'h0c;
   localparam logic [4:0] ADDR_MCR = 5'h10;
   localparam logic [4:0] ADDR_LSR = 5'h14;
   localparam logic [4:0] ADDR_MSR = 5'h18;
   localparam logic [4:0] ADDR_SCR = 5'h1c;
   // Field positions
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_AUXA = 2;
   localparam int MCR_AUXB = 3;
   localparam int MCR_LOOP = 4;
   localparam int LCR_DIVSEL = 7;
   localparam int IER_MODEM = 3;
   localparam int IER_LINE = 2;
   localparam int IER_RXDATA = 0;
   localparam int IER_TXEMPTY = 1;
   // Reset values and bus response codes
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] IER_RESET = 8'h00;
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam logic [7:0] SCR_RESET = 8'h00;
   localparam logic [15:0] DIV_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Receiver events from the shift/framing logic
   typedef struct packed {
      logic load;
      logic [7:0] data;
      logic parity_err;
      logic frame_err;
      logic brk;
   } umsb_rx_s;

   // Transmitter status from the shift logic
   typedef struct packed {
      logic shift_empty;
      logic take;
   } umsb_tx_s;

   typedef struct packed {
      logic cts;
      logic dsr;
      logic ri;
      logic dcd;
   } umsb_modem_s;

   typedef enum logic [1:0] {UMSB_IDLE, UMSB_RESP} umsb_bus_e;
endpackage

// ===== hdl/umsb_sync.sv
`timescale 1ns/100ps
module umsb_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   // Modem pins start from the idle high level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '1;
         q <= '1;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule

// ===== hdl/umsb_baud.sv
`timescale 1ns/100ps
module umsb_baud #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Divisor
   input wire logic [DIV_W-1:0] divisor,
   input wire logic reload,
   // Output
   output logic baud_tick
);
   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] next_count;
   logic next_tick;

   // A zero divisor wraps through all 2^DIV_W states
   always_comb begin
      next_count = count - {{(DIV_W-1){1'b0}}, 1'b1};
      next_tick = 1'b0;
      if (reload) begin
         next_count = divisor;
      end else if (count == {{(DIV_W-1){1'b0}}, 1'b1}) begin
         next_count = divisor;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         baud_tick <= 1'b0;
      end else begin
         count <= next_count;
         baud_tick <= next_tick;
      end
   end
endmodule

// ===== hdl/umsb_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module umsb_top
   import umsb_pkg::*;
#(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // AXI4-Lite write address, data and response
   input wire logic [4:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [4:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Modem lines, active low on the wire
   output logic DTR_N,
   output logic RTS_N,
   input wire logic CTS_N,
   input wire logic DSR_N,
   input wire logic RI_N,
   input wire logic DCD_N,
   // Serial lines
   output logic TXD,
   input wire logic RXD,
   // Shift-register side of the UART, plus the interrupt output
   input wire logic TX_SHIFT_OUT,
   output logic RX_SHIFT_IN,
   input wire umsb_pkg::umsb_rx_s RX_EVT,
   input wire umsb_pkg::umsb_tx_s TX_EVT,
   output logic [7:0] TX_HOLDING,
   output logic TX_HOLD_FULL,
   output logic [7:0] LINE_CTRL,
   output logic BAUD_TICK,
   output logic IRQ
);
   import umsb_pkg::*;

   logic [7:0] modem_control_reg, next_mcr;
   logic [7:0] irq_enable_reg, next_ier;
   logic [7:0] line_ctrl, next_lcr;
   logic [7:0] spare_storage_reg, next_scr;
   logic [7:0] divisor_low_byte, next_dll;
   logic [7:0] divisor_high_byte, next_dlm;
   logic [7:0] rx_buffer, next_rbr;
   logic [7:0] tx_holding, next_thr;
   logic [3:0] flags, next_flags;
   logic data_ready_flag, next_dr;
   logic tx_hold_empty_flag, next_tx_hold_empty_flag;
   umsb_modem_s prev_st, next_prev;
   logic [3:0] chg, next_chg;
   umsb_bus_e wstate, next_wstate, rstate, next_rstate;
   logic aw_got, next_aw_got, w_got, next_w_got;
   logic [4:0] aw_addr, next_aw_addr;
   logic [7:0] w_byte, next_w_byte;
   logic w_en, next_w_en;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic reload, next_reload;
   logic [3:0] pins_sync;
   umsb_modem_s st;
   logic loopback, divsel, wr_fire, rd_fire, wr_ok, rd_ok;
   logic tx_idle_flag;
   logic [7:0] lsr_val, msr_val;

   // Pins pass two flops before anything looks at them
   umsb_sync #(.WIDTH(4)) u_sync (
      .clk(CORE_CLK),
      .rst(RESET),
      .d({DCD_N, RI_N, DSR_N, CTS_N}),
      .q(pins_sync)
   );

   umsb_baud #(.DIV_W(DIV_W)) u_baud (
      .clk(CORE_CLK),
      .rst(RESET),
      .divisor({divisor_high_byte, divisor_low_byte}),
      .reload(reload),
      .baud_tick(BAUD_TICK)
   );

   assign loopback = modem_control_reg[MCR_LOOP];
   assign divsel = line_ctrl[LCR_DIVSEL];

   always_comb begin
      if (loopback) begin
         st.cts = modem_control_reg[MCR_RTS];
         st.dsr = modem_control_reg[MCR_DTR];
         st.ri = modem_control_reg[MCR_AUXA];
         st.dcd = modem_control_reg[MCR_AUXB];
      end else begin
         st.cts = ~pins_sync[0];
         st.dsr = ~pins_sync[1];
         st.ri = ~pins_sync[2];
         st.dcd = ~pins_sync[3];
      end
   end

   assign DTR_N = ~modem_control_reg[MCR_DTR];
   assign RTS_N = ~modem_control_reg[MCR_RTS];
   // aux bits have no pins; they only feed loop-back status
   assign TXD = loopback ? 1'b1 : TX_SHIFT_OUT;
   // shift output returns to receiver with no delay
   assign RX_SHIFT_IN = loopback ? TX_SHIFT_OUT : RXD;

   // both holding and shift register empty
   assign tx_idle_flag = tx_hold_empty_flag & TX_EVT.shift_empty;
   assign lsr_val = {1'b0, tx_idle_flag, tx_hold_empty_flag, flags,
                     data_ready_flag};
   assign msr_val = {st.dcd, st.ri, st.dsr, st.cts, chg};

   assign TX_HOLDING = tx_holding;
   assign TX_HOLD_FULL = ~tx_hold_empty_flag;
   assign LINE_CTRL = line_ctrl;

   // Bus channel state
   assign AWREADY = (wstate == UMSB_IDLE) & ~aw_got;
   assign WREADY = (wstate == UMSB_IDLE) & ~w_got;
   assign BVALID = (wstate == UMSB_RESP);
   assign BRESP = bresp;
   assign ARREADY = (rstate == UMSB_IDLE);
   assign RVALID = (rstate == UMSB_RESP);
   assign RDATA = rdata;
   assign RRESP = rresp;

   // Write happens once both address and data are held or present on the bus
   assign wr_fire = (wstate == UMSB_IDLE) & (aw_got | AWVALID)
                    & (w_got | WVALID);
   assign rd_fire = ARVALID & ARREADY;

   function automatic logic mapped(input logic [4:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= ADDR_SCR);
   endfunction

   always_comb begin
      logic [4:0] wa;
      logic [7:0] wb;
      wa = aw_got ? aw_addr : AWADDR;
      wb = w_got ? w_byte : WDATA[7:0];
      wr_ok = mapped(wa) && (wa != ADDR_LSR);
      next_wstate = wstate;
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_aw_addr = aw_addr;
      next_w_byte = w_byte;
      next_w_en = w_en;
      next_bresp = bresp;
      next_mcr = modem_control_reg;
      next_ier = irq_enable_reg;
      next_lcr = line_ctrl;
      next_scr = spare_storage_reg;
      next_dll = divisor_low_byte;
      next_dlm = divisor_high_byte;
      next_thr = tx_holding;
      next_reload = 1'b0;
      next_tx_hold_empty_flag = tx_hold_empty_flag;
      next_chg = chg;
      case (wstate)
         UMSB_IDLE: begin
            if (AWVALID && AWREADY) begin
               next_aw_got = 1'b1;
               next_aw_addr = AWADDR;
            end
            if (WVALID && WREADY) begin
               next_w_got = 1'b1;
               next_w_byte = WDATA[7:0];
               // Strobe kept with the data when address comes later
               next_w_en = WSTRB[0];
            end
            if (wr_fire) begin
               next_aw_got = 1'b0;
               next_w_got = 1'b0;
               next_wstate = UMSB_RESP;
               next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
               if (wr_ok && (w_got ? w_en : WSTRB[0])) begin
                  case (wa)
                     ADDR_RBR_THR_DLL: begin
                        if (divsel) begin
                           next_dll = wb;
                           next_reload = 1'b1;
                        end else begin
                           next_thr = wb;
                           next_tx_hold_empty_flag = 1'b0;
                        end
                     end
                     ADDR_IER_DLM: begin
                        if (divsel) begin
                           next_dlm = wb;
                           next_reload = 1'b1;
                        end else begin
                           next_ier = {4'h0, wb[3:0]};
                        end
                     end
                     ADDR_LCR: next_lcr = wb;
                     ADDR_MCR: next_mcr = {3'h0, wb[4:0]};
                     ADDR_MSR: next_chg = wb[3:0];
                     ADDR_SCR: next_scr = wb;
                     default: next_scr = spare_storage_reg;
                  endcase
               end
            end
         end
         UMSB_RESP: begin
            if (BREADY) begin
               next_wstate = UMSB_IDLE;
            end
         end
         default: next_wstate = UMSB_IDLE;
      endcase
      if (TX_EVT.take) begin
         next_tx_hold_empty_flag = 1'b1;
      end
      if (rd_fire && ARADDR == ADDR_MSR) begin
         next_chg = 4'h0;
      end
      // change detection, set wins over clear
      if (st.cts != prev_st.cts) begin
         next_chg[0] = 1'b1;
      end
      if (st.dsr != prev_st.dsr) begin
         next_chg[1] = 1'b1;
      end
      if (!st.ri && prev_st.ri) begin
         next_chg[2] = 1'b1;
      end
      if (st.dcd != prev_st.dcd) begin
         next_chg[3] = 1'b1;
      end
   end

   // Read path and receive flags
   always_comb begin
      rd_ok = mapped(ARADDR);
      next_rstate = rstate;
      next_rdata = rdata;
      next_rresp = rresp;
      next_rbr = rx_buffer;
      next_dr = data_ready_flag;
      next_flags = flags;
      next_prev = st;
      case (rstate)
         UMSB_IDLE: begin
            if (rd_fire) begin
               next_rstate = UMSB_RESP;
               next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
               next_rdata = 32'h0000_0000;
               case (ARADDR)
                  ADDR_RBR_THR_DLL: begin
                     if (divsel) begin
                        next_rdata[7:0] = divisor_low_byte;
                     end else begin
                        next_rdata[7:0] = rx_buffer;
                        next_dr = 1'b0;
                     end
                  end
                  ADDR_IER_DLM: next_rdata[7:0] = divsel ?
                     divisor_high_byte : irq_enable_reg;
                  ADDR_LCR: next_rdata[7:0] = line_ctrl;
                  ADDR_MCR: next_rdata[7:0] = modem_control_reg;
                  ADDR_LSR: begin
                     next_rdata[7:0] = lsr_val;
                     next_flags = 4'h0;
                  end
                  ADDR_MSR: next_rdata[7:0] = msr_val;
                  ADDR_SCR: next_rdata[7:0] = spare_storage_reg;
                  default: next_rdata = 32'h0000_0000;
               endcase
            end
         end
         UMSB_RESP: begin
            if (RREADY) begin
               next_rstate = UMSB_IDLE;
            end
         end
         default: next_rstate = UMSB_IDLE;
      endcase
      // Receive events win over a same-cycle clearing read
      if (RX_EVT.load) begin
         next_rbr = RX_EVT.data;
         next_dr = 1'b1;
         if (data_ready_flag) begin
            next_flags[0] = 1'b1;
         end
         if (RX_EVT.parity_err) begin
            next_flags[1] = 1'b1;
         end
         if (RX_EVT.frame_err) begin
            next_flags[2] = 1'b1;
         end
      end
      if (RX_EVT.brk) begin
         next_flags[3] = 1'b1;
      end
   end

   assign IRQ = (irq_enable_reg[IER_LINE] & |flags)
              | (irq_enable_reg[IER_RXDATA] & data_ready_flag)
              | (irq_enable_reg[IER_TXEMPTY] & tx_hold_empty_flag)
              | (irq_enable_reg[IER_MODEM] & |chg);

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         modem_control_reg <= MCR_RESET;
         irq_enable_reg <= IER_RESET;
         line_ctrl <= LCR_RESET;
         spare_storage_reg <= SCR_RESET;
         divisor_low_byte <= DIV_RESET[7:0];
         divisor_high_byte <= DIV_RESET[15:8];
         rx_buffer <= 8'h00;
         tx_holding <= 8'h00;
         flags <= 4'h0;
         data_ready_flag <= 1'b0;
         tx_hold_empty_flag <= 1'b1;
         prev_st <= '0;
         chg <= 4'h0;
         wstate <= UMSB_IDLE;
         rstate <= UMSB_IDLE;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 5'h00;
         w_byte <= 8'h00;
         w_en <= 1'b0;
         bresp <= 2'b00;
         rresp <= 2'b00;
         rdata <= 32'h0000_0000;
         reload <= 1'b0;
      end else begin
         modem_control_reg <= next_mcr;
         irq_enable_reg <= next_ier;
         line_ctrl <= next_lcr;
         spare_storage_reg <= next_scr;
         divisor_low_byte <= next_dll;
         divisor_high_byte <= next_dlm;
         rx_buffer <= next_rbr;
         tx_holding <= next_thr;
         flags <= next_flags;
         data_ready_flag <= next_dr;
         tx_hold_empty_flag <= next_tx_hold_empty_flag;
         prev_st <= next_prev;
         chg <= next_chg;
         wstate <= next_wstate;
         rstate <= next_rstate;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         aw_addr <= next_aw_addr;
         w_byte <= next_w_byte;
         w_en <= next_w_en;
         bresp <= next_bresp;
         rresp <= next_rresp;
         rdata <= next_rdata;
         reload <= next_reload;
      end
   end
endmodule

// ===== testbench/umsb_top_chk.sv
`timescale 1ns/100ps
module umsb_top_chk
   import umsb_pkg::*;
#(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // Register bus
   input wire logic [4:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic [4:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   // Lines
   input wire logic DTR_N,
   input wire logic RTS_N,
   input wire logic TXD,
   input wire logic RXD,
   input wire logic TX_SHIFT_OUT,
   input wire logic RX_SHIFT_IN,
   input wire umsb_pkg::umsb_tx_s TX_EVT,
   input wire logic TX_HOLD_FULL
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   logic aw_go;
   logic ar_lsr;
   assign aw_go = AWVALID && AWREADY && WVALID && WREADY && WSTRB[0];
   assign ar_lsr = ARVALID && ARREADY && ARADDR == ADDR_LSR;
   property p_ctrl_pins;
      aw_go && AWADDR == ADDR_MCR |=>
         DTR_N == !$past(WDATA[0]) && RTS_N == !$past(WDATA[1]);
   endproperty
   a_ctrl_pins: assert property (p_ctrl_pins)
      else $error("control pins do not follow written bits");
   property p_loop_feed;
      TXD != TX_SHIFT_OUT |-> RX_SHIFT_IN == TX_SHIFT_OUT;
   endproperty
   a_loop_feed: assert property (p_loop_feed)
      else $error("looped receive input not fed by transmitter");
   property p_norm_path;
      RX_SHIFT_IN != TX_SHIFT_OUT |->
         TXD == TX_SHIFT_OUT && RX_SHIFT_IN == RXD;
   endproperty
   a_norm_path: assert property (p_norm_path)
      else $error("serial path wrong outside loop-back");
   property p_lsr_top;
      ar_lsr |=> RVALID && !RDATA[7];
   endproperty
   a_lsr_top: assert property (p_lsr_top)
      else $error("line status bit 7 not zero");
   property p_lsr_ro;
      aw_go && AWADDR == ADDR_LSR |=> BVALID && BRESP == RESP_SLVERR;
   endproperty
   a_lsr_ro: assert property (p_lsr_ro)
      else $error("write to line status not refused");
   property p_hold_empty;
      ar_lsr |=> RDATA[5] == !$past(TX_HOLD_FULL);
   endproperty
   a_hold_empty: assert property (p_hold_empty)
      else $error("holding empty flag disagrees with holding state");
   property p_tx_idle;
      ar_lsr |=>
         RDATA[6] == (!$past(TX_HOLD_FULL) && $past(TX_EVT.shift_empty));
   endproperty
   a_tx_idle: assert property (p_tx_idle)
      else $error("transmitter empty flag wrong");
   property p_unmapped;
      ARVALID && ARREADY && ARADDR[1:0] != 2'b00 |=>
         RVALID && RRESP == RESP_SLVERR && RDATA == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unaligned read not refused");
endmodule

bind umsb_top umsb_top_chk #(.DIV_W(DIV_W)) u_chk (.CORE_CLK, .RESET,
   .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
   .BVALID, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .DTR_N,
   .RTS_N, .TXD, .RXD, .TX_SHIFT_OUT, .RX_SHIFT_IN, .TX_EVT, .TX_HOLD_FULL);

// ===== testbench/umsb_modem_model.sv
`timescale 1ns/100ps
module umsb_modem_model (
   // Clock
   input wire logic clk,
   // Wanted states, 1 = asserted: cts, dsr, ri, dcd
   input wire logic [3:0] want,
   // Lines, low = asserted
   output logic CTS_N,
   output logic DSR_N,
   output logic RI_N,
   output logic DCD_N,
   output logic RXD
);
   integer seed = 32'h1f2e3d4c;
   int lag = 0;
   logic [3:0] shown = 4'h0;
   // Equipment settles at its own pace, so changes lag up to 3 cycles
   always @(posedge clk) begin
      if (want != shown) begin
         if (lag == 0) begin
            shown <= want;
            lag <= $unsigned($random(seed)) % 4;
         end else begin
            lag <= lag - 1;
         end
      end
   end
   assign {DCD_N, RI_N, DSR_N, CTS_N} = ~shown;
   // No frames are sent, the line rests at mark
   assign RXD = 1'b1;
endmodule

// ===== testbench/uart_modem_status_baud_gen_bench.sv
`timescale 1ns/100ps
module uart_modem_status_baud_gen_bench;
   import umsb_pkg::*;
`define CHK(a, b) chk_val(32'(a), 32'(b))
   logic CORE_CLK = 1'b0;
   logic RESET = 1'b1;
   logic [4:0] AWADDR = 5'h0, ARADDR = 5'h0;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [3:0] WSTRB = 4'h1;
   logic [3:0] want = 4'h0;
   logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, TX_SHIFT_OUT = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DTR_N, RTS_N, TXD;
   logic RX_SHIFT_IN, TX_HOLD_FULL, BAUD_TICK, IRQ;
   logic CTS_N, DSR_N, RI_N, DCD_N, RXD;
   logic [1:0] BRESP, RRESP;
   logic [7:0] TX_HOLDING, LINE_CTRL, d;
   umsb_rx_s RX_EVT = '0;
   umsb_tx_s TX_EVT = '{1'b1, 1'b0};
   logic [31:0] rq[$];
   logic [1:0] bq[$];
   logic [15:0] dv[3] = '{16'd3, 16'd1, 16'h0102};
   integer seed = 32'ha3313bbf;
   int err_count = 0, n_checks = 0, n;
   always #25 CORE_CLK = ~CORE_CLK;
   umsb_top u_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(1'b1), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(1'b1),
      .DTR_N(DTR_N), .RTS_N(RTS_N), .CTS_N(CTS_N), .DSR_N(DSR_N),
      .RI_N(RI_N), .DCD_N(DCD_N), .TXD(TXD), .RXD(RXD),
      .TX_SHIFT_OUT(TX_SHIFT_OUT), .RX_SHIFT_IN(RX_SHIFT_IN),
      .RX_EVT(RX_EVT), .TX_EVT(TX_EVT), .TX_HOLDING(TX_HOLDING),
      .TX_HOLD_FULL(TX_HOLD_FULL), .LINE_CTRL(LINE_CTRL),
      .BAUD_TICK(BAUD_TICK), .IRQ(IRQ));
   umsb_modem_model u_modem (.clk(CORE_CLK), .want(want), .CTS_N(CTS_N),
      .DSR_N(DSR_N), .RI_N(RI_N), .DCD_N(DCD_N), .RXD(RXD));
   task automatic chk_val(input logic [31:0] a, input logic [31:0] b);
      n_checks++;
      if (a !== b) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b);
      end
   endtask
   task automatic lost(input int t);
      if (t >= 40) begin
         err_count++;
         $display("CHECK FAILED at %0t: bus gave no answer", $time);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge CORE_CLK);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      int t = 0;
      rq.push_back(e);
      ARADDR <= a;
      ARVALID <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         t++;
      end while (!ARREADY && t < 40);
      ARVALID <= 1'b0;
      do begin
         @(posedge CORE_CLK);
         t++;
      end while (!RVALID && t < 40);
      lost(t);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v,
         input logic [1:0] r);
      int t = 0;
      logic aw = 1'b1;
      logic w = 1'b1;
      logic fin = 1'b0;
      bq.push_back(r);
      AWADDR <= a;
      WDATA <= {24'h0, v};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         t++;
         fin = BVALID && !aw && !w;
         if (aw && AWREADY) AWVALID <= 1'b0;
         if (w && WREADY) WVALID <= 1'b0;
         aw = aw && !AWREADY;
         w = w && !WREADY;
      end while (!fin && t < 40);
      lost(t);
   endtask
   task automatic rx_pulse(input logic [7:0] v, input logic [2:0] f);
      RX_EVT <= '{1'b1, v, f[0], f[1], f[2]};
      tick(1);
      RX_EVT <= '0;
      tick(1);
   endtask
   task automatic gap(output int c);
      c = 0;
      do begin
         @(posedge CORE_CLK);
         c++;
      end while (!BAUD_TICK && c < 70000);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Each answer is matched against the oldest note of its driver
   always @(posedge CORE_CLK) begin
      if (RVALID) `CHK(RDATA, rq.pop_front());
      if (BVALID) `CHK(BRESP, bq.pop_front());
   end
   initial begin
      #(80000 * 50);
      err_count++;
      end_of_test();
   end
   initial begin
      tick(2);
      RESET <= 1'b0;
      tick(1);
      `CHK({DTR_N, RTS_N, IRQ}, 3'b110);
      rd(ADDR_LSR, 32'h60);
      rd(ADDR_SCR, 32'h0);
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_MCR, 8'(i), RESP_OKAY);
         `CHK({DTR_N, RTS_N}, {~i[0], ~i[1]});
         rd(ADDR_MCR, i);
      end
      d = $random(seed);
      wr(ADDR_SCR, d, RESP_OKAY);
      WSTRB <= 4'h0;
      wr(ADDR_SCR, ~d, RESP_OKAY);
      WSTRB <= 4'h1;
      rd(ADDR_SCR, d);
      done("control");
      for (int k = 0; k < 4; k++) begin
         want <= 4'(1 << k);
         tick(12);
         rd(ADDR_MSR, (32'h10 << k) | (k == 2 ? 0 : 1 << k));
         rd(ADDR_MSR, 32'h10 << k);
         want <= 4'h0;
         tick(12);
         rd(ADDR_MSR, 32'h1 << k);
      end
      wr(ADDR_IER_DLM, 8'h08, RESP_OKAY);
      wr(ADDR_MSR, 8'h05, RESP_OKAY);
      `CHK(IRQ, 1'b1);
      rd(ADDR_MSR, 32'h05);
      `CHK(IRQ, 1'b0);
      wr(ADDR_MSR, 8'h0f, RESP_OKAY);
      wr(ADDR_MSR, 8'h00, RESP_OKAY);
      `CHK(IRQ, 1'b0);
      wr(ADDR_IER_DLM, 8'h00, RESP_OKAY);
      wr(ADDR_MSR, 8'h02, RESP_OKAY);
      `CHK(IRQ, 1'b0);
      rd(ADDR_MSR, 32'h02);
      done("status");
      want <= 4'hf;
      tick(12);
      rd(ADDR_MSR, 32'hfb);
      wr(ADDR_MCR, 8'h10, RESP_OKAY);
      tick(4);
      rd(ADDR_MSR, 32'h0f);
      for (int b = 1; b >= 0; b--) begin
         TX_SHIFT_OUT <= 1'(b);
         tick(1);
         `CHK({TXD, RX_SHIFT_IN}, {1'b1, 1'(b)});
      end
      wr(ADDR_MCR, 8'h1f, RESP_OKAY);
      tick(4);
      rd(ADDR_MSR, 32'hfb);
      `CHK({DTR_N, RTS_N}, 2'b00);
      want <= 4'h0;
      wr(ADDR_MCR, 8'h00, RESP_OKAY);
      tick(12);
      rd(ADDR_MSR, 32'h0f);
      done("loop");
      d = $random(seed);
      rx_pulse(d, 3'b000);
      rd(ADDR_LSR, 32'h61);
      rd(ADDR_RBR_THR_DLL, d);
      rd(ADDR_LSR, 32'h60);
      rx_pulse(~d, 3'b000);
      rx_pulse(d, 3'b000);
      rd(ADDR_LSR, 32'h63);
      rd(ADDR_LSR, 32'h61);
      rd(ADDR_RBR_THR_DLL, d);
      for (int k = 0; k < 3; k++) begin
         rx_pulse(d, 3'(1 << k));
         rd(ADDR_LSR, 32'h61 | (32'h4 << k));
         rd(ADDR_RBR_THR_DLL, d);
         rd(ADDR_LSR, 32'h60);
      end
      wr(ADDR_LSR, 8'hff, RESP_SLVERR);
      rd(ADDR_LSR, 32'h60);
      wr(ADDR_RBR_THR_DLL, d, RESP_OKAY);
      `CHK({TX_HOLD_FULL, TX_HOLDING}, {1'b1, d});
      rd(ADDR_LSR, 32'h00);
      TX_EVT <= '{1'b0, 1'b1};
      tick(1);
      TX_EVT <= '{1'b0, 1'b0};
      tick(1);
      rd(ADDR_LSR, 32'h20);
      TX_EVT <= '{1'b1, 1'b0};
      tick(1);
      rd(ADDR_LSR, 32'h60);
      done("line");
      wr(ADDR_LCR, 8'h80, RESP_OKAY);
      `CHK(LINE_CTRL, 8'h80);
      wr(ADDR_IER_DLM, 8'h00, RESP_OKAY);
      wr(ADDR_RBR_THR_DLL, 8'h00, RESP_OKAY);
      gap(n);
      `CHK(n >= 65534 && n <= 65538, 1'b1);
      for (int j = 0; j < 3; j++) begin
         wr(ADDR_IER_DLM, dv[j][15:8], RESP_OKAY);
         wr(ADDR_RBR_THR_DLL, dv[j][7:0], RESP_OKAY);
         gap(n);
         gap(n);
         `CHK(n, dv[j]);
         rd(ADDR_RBR_THR_DLL, dv[j][7:0]);
         rd(ADDR_IER_DLM, dv[j][15:8]);
      end
      wr(ADDR_LCR, 8'h00, RESP_OKAY);
      rd(ADDR_IER_DLM, 32'h0);
      rd(5'h1d, 32'h0);
      done("divisor");
      tick(2);
      end_of_test();
   end
endmodule
